// ---- nbbm_ctrl.sv ----
`timescale 1ns/10ps
`include "nbbm_consts.svh"
module nbbm_ctrl
	import nbbm_pkg::*;
#(
	parameter int BLOCKS     = `NBBM_BLOCKS,
	parameter int LOG_BLOCKS = `NBBM_LOG_BLOCKS,
	parameter int PROG_CYC   = `NBBM_T_PROG_US * `NBBM_CLK_MHZ,
	parameter int BERS_CYC   = `NBBM_T_BERS_US * `NBBM_CLK_MHZ
) (
	input  wire logic                    sys_clk_i,
	input  wire logic                    rst_i,
	input  wire logic                    ce_i,
	input  wire logic                    req_valid_i,
	output logic                         req_ready_o,
	input  wire nbbm_op_type             req_op_i,
	input  wire logic [`NBBM_BLK_W-1:0]  req_lbn_i,
	input  wire logic [`NBBM_PAGE_W-1:0] req_page_i,
	input  wire logic [6:0]              req_idx_i,
	input  wire logic [7:0]              req_data_i,
	output logic                         rsp_valid_o,
	output nbbm_code_type                rsp_code_o,
	output logic [7:0]                   rsp_data_o,
	output logic                         retire_valid_o,
	output logic [`NBBM_BLK_W-1:0]       retire_old_o,
	output logic [`NBBM_BLK_W-1:0]       retire_new_o,
	output logic                         scan_done_o,
	output logic                         nand_ce_n_o,
	output logic                         nand_cle_o,
	output logic                         nand_ale_o,
	output logic                         nand_we_n_o,
	output logic                         read_strobe_line_n_o,
	output logic                         nand_wp_n_o,
	input  wire logic [7:0]              nand_io_i,
	output logic [7:0]                   nand_io_o,
	output logic                         nand_io_oe_n_o,
	input  wire logic                    nand_rb_i
);
	localparam int CW = `NBBM_CNT_W;
	// ========================================
	// pin phase lengths, least times rounded up
	localparam logic [CW-1:0] LO_CYC = CW'((`NBBM_T_LO_NS + `NBBM_T_CLK_NS
		- 1) / `NBBM_T_CLK_NS + `NBBM_SYNC_LAT);
	localparam logic [CW-1:0] HI_CYC = CW'((`NBBM_T_HI_NS + `NBBM_T_CLK_NS
		- 1) / `NBBM_T_CLK_NS);
	localparam logic [CW-1:0] WB_CYC = CW'((`NBBM_T_WB_NS + `NBBM_T_CLK_NS
		- 1) / `NBBM_T_CLK_NS + `NBBM_SYNC_LAT);
	localparam logic [CW-1:0] CEH_CYC = CW'(`NBBM_T_CEH_NS
		/ `NBBM_T_CLK_NS + 1);
	localparam logic [CW-1:0] R_CYC = CW'(`NBBM_T_R_US * `NBBM_CLK_MHZ);
	localparam logic [CW-1:0] RST_CYC = CW'(`NBBM_T_RST_US * `NBBM_CLK_MHZ);

	nbbm_st_type   s_q;
	nbbm_st_type   s_d;
	nbbm_kind_type kind;
	logic [7:0]    val;
	logic [15:0]   row;
	logic [CW-1:0] limit;
	logic [3:0]    syn;
	logic          odd;
	logic [7:0]    fixd;

	nbbm_map_if #(.AW(`NBBM_BLK_W), .DW(`NBBM_BLK_W)) map ();
	nbbm_map_mem #(.AW(`NBBM_BLK_W), .DW(`NBBM_BLK_W)) u_map (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.map       (map.mem)
	);

	// ========================================
	// hamming parity for the check byte
	function automatic logic [3:0] par4(input logic [7:0] dd);
		logic [3:0] p;
		p[0] = dd[0] ^ dd[1] ^ dd[3] ^ dd[4] ^ dd[6];
		p[1] = dd[0] ^ dd[2] ^ dd[3] ^ dd[5] ^ dd[6];
		p[2] = dd[1] ^ dd[2] ^ dd[3] ^ dd[7];
		p[3] = dd[4] ^ dd[5] ^ dd[6] ^ dd[7];
		return p;
	endfunction

	assign row = {s_q.pbn, s_q.page};

	// syndrome decode: single error flips a data bit, double is flagged
	always_comb begin
		logic [3:0] pos [8];
		pos  = '{4'h3, 4'h5, 4'h6, 4'h7, 4'h9, 4'hA, 4'hB, 4'hC};
		syn  = s_q.rd[3:0] ^ par4(s_q.rd2);
		odd  = ^{s_q.rd2, s_q.rd[4:0]};
		fixd = s_q.rd2;
		for (int i = 0; i < 8; i++) begin
			if (odd && syn == pos[i]) begin
				fixd[i] = ~s_q.rd2[i];
			end
		end
	end

	// sequence of pin cycles for each operation
	always_comb begin
		kind  = NBBM_K_END;
		val   = 8'h00;
		limit = R_CYC;
		case (s_q.op)
		NBBM_OP_READ: begin
			case (s_q.step)
			4'h0: begin kind = NBBM_K_CMD; val = `NBBM_CMD_READ0; end
			4'h1: begin kind = NBBM_K_ADR; val = {s_q.idx, 1'b0}; end
			4'h2: begin kind = NBBM_K_ADR; val = row[7:0]; end
			4'h3: begin kind = NBBM_K_ADR; val = row[15:8]; end
			4'h4: kind = NBBM_K_WAIT;
			4'h5, 4'h6: kind = NBBM_K_DOUT;
			default: kind = NBBM_K_END;
			endcase
		end
		NBBM_OP_PROG: begin
			limit = CW'(PROG_CYC);
			case (s_q.step)
			4'h0: begin kind = NBBM_K_CMD; val = `NBBM_CMD_READ0; end
			4'h1: begin kind = NBBM_K_CMD; val = `NBBM_CMD_PROG; end
			4'h2: begin kind = NBBM_K_ADR; val = {s_q.idx, 1'b0}; end
			4'h3: begin kind = NBBM_K_ADR; val = row[7:0]; end
			4'h4: begin kind = NBBM_K_ADR; val = row[15:8]; end
			4'h5: begin kind = NBBM_K_DIN; val = s_q.data; end
			4'h6: begin
				kind = NBBM_K_DIN;
				val  = {3'h0, ^{s_q.data, par4(s_q.data)}, par4(s_q.data)};
			end
			4'h7: begin kind = NBBM_K_CMD; val = `NBBM_CMD_PROG_GO; end
			4'h8: kind = NBBM_K_WAIT;
			4'h9: begin kind = NBBM_K_CMD; val = `NBBM_CMD_STATUS; end
			4'hA: kind = NBBM_K_DOUT;
			default: kind = NBBM_K_END;
			endcase
		end
		NBBM_OP_ERASE: begin
			limit = CW'(BERS_CYC);
			case (s_q.step)
			4'h0: begin kind = NBBM_K_CMD; val = `NBBM_CMD_ERASE; end
			4'h1: begin kind = NBBM_K_ADR; val = row[7:0]; end
			4'h2: begin kind = NBBM_K_ADR; val = row[15:8]; end
			4'h3: begin kind = NBBM_K_CMD; val = `NBBM_CMD_ERASE_GO; end
			4'h4: kind = NBBM_K_WAIT;
			4'h5: begin kind = NBBM_K_CMD; val = `NBBM_CMD_STATUS; end
			4'h6: kind = NBBM_K_DOUT;
			default: kind = NBBM_K_END;
			endcase
		end
		NBBM_OP_RESET: begin
			limit = RST_CYC;
			case (s_q.step)
			4'h0: begin kind = NBBM_K_CMD; val = `NBBM_CMD_RESET; end
			4'h1: kind = NBBM_K_WAIT;
			default: kind = NBBM_K_END;
			endcase
		end
		default: begin
			case (s_q.step)
			4'h0: begin kind = NBBM_K_CMD; val = `NBBM_CMD_SPARE; end
			4'h1: begin kind = NBBM_K_ADR; val = `NBBM_MARK_COL; end
			4'h2: begin kind = NBBM_K_ADR; val = row[7:0]; end
			4'h3: begin kind = NBBM_K_ADR; val = row[15:8]; end
			4'h4: kind = NBBM_K_WAIT;
			4'h5: kind = NBBM_K_DOUT;
			default: kind = NBBM_K_END;
			endcase
		end
		endcase
	end

	// ========================================
	// main sequencer
	always_comb begin
		s_d           = s_q;
		s_d.rsp_valid = 1'b0;
		s_d.ret_valid = 1'b0;
		s_d.wp_n      = 1'b1;
		s_d.rb1       = nand_rb_i;
		s_d.rb2       = s_q.rb1;
		s_d.io1       = nand_io_i;
		s_d.io2       = s_q.io1;
		map.we        = 1'b0;
		map.waddr     = s_q.lbn;
		map.wdata     = s_q.pbn;
		case (s_q.st)
		NBBM_IDLE: begin
			s_d.cnt  = '0;
			s_d.step = 4'h0;
			if (req_valid_i) begin
				s_d.op   = req_op_i;
				s_d.lbn  = req_lbn_i;
				s_d.page = req_page_i;
				s_d.idx  = req_idx_i;
				s_d.data = req_data_i;
				if (!s_q.rb2 && req_op_i != NBBM_OP_RESET) begin
					s_d.rsp_valid = 1'b1;
					s_d.rsp_code  = NBBM_RC_REFUSED;
				end else if (req_op_i == NBBM_OP_SCAN) begin
					s_d.pbn       = '0;
					s_d.page      = '0;
					s_d.lcnt      = '0;
					s_d.good      = '1;
					s_d.spare     = (`NBBM_BLK_W+1)'(BLOCKS);
					s_d.scan_done = 1'b0;
					s_d.st        = NBBM_SEQ;
				end else if (req_op_i == NBBM_OP_RESET) begin
					s_d.st = NBBM_SEQ;
				end else begin
					s_d.st = NBBM_MAP;
				end
			end
		end
		NBBM_MAP: begin
			s_d.cnt = s_q.cnt + 1'b1;
			if (s_q.cnt == CW'(1)) begin
				s_d.pbn = map.rdata;
				s_d.cnt = '0;
				if (!s_q.scan_done
					|| 32'(s_q.lbn) >= LOG_BLOCKS
					|| !s_q.good[map.rdata]
					|| (s_q.op == NBBM_OP_PROG
					&& {map.rdata, s_q.page} == s_q.last_row
					&& s_q.nop == 2'(`NBBM_NOP_MAIN))) begin
					s_d.rsp_valid = 1'b1;
					s_d.rsp_code  = NBBM_RC_REFUSED;
					s_d.st        = NBBM_CEH;
				end else begin
					s_d.st = NBBM_SEQ;
				end
			end
		end
		NBBM_SEQ: begin
			s_d.cnt  = '0;
			s_d.ce_n = 1'b0;
			s_d.io   = val;
			s_d.st   = NBBM_LO;
			case (kind)
			NBBM_K_CMD: begin s_d.cle = 1'b1; s_d.we_n = 1'b0; s_d.oe_n = 1'b0; end
			NBBM_K_ADR: begin s_d.ale = 1'b1; s_d.we_n = 1'b0; s_d.oe_n = 1'b0; end
			NBBM_K_DIN: begin s_d.we_n = 1'b0; s_d.oe_n = 1'b0; end
			NBBM_K_DOUT: s_d.re_n = 1'b0;
			NBBM_K_WAIT: s_d.st = NBBM_WB;
			default: s_d.st = NBBM_FIN;
			endcase
		end
		NBBM_LO: begin
			s_d.cnt = s_q.cnt + 1'b1;
			if (s_q.cnt == LO_CYC - 1'b1) begin
				if (!s_q.re_n) begin
					s_d.rd2 = s_q.rd;
					s_d.rd  = s_q.io2;
				end
				s_d.we_n = 1'b1;
				s_d.re_n = 1'b1;
				s_d.cnt  = '0;
				s_d.st   = NBBM_HI;
			end
		end
		NBBM_HI: begin
			s_d.cnt = s_q.cnt + 1'b1;
			if (s_q.cnt == HI_CYC - 1'b1) begin
				s_d.cle  = 1'b0;
				s_d.ale  = 1'b0;
				s_d.oe_n = 1'b1;
				s_d.step = s_q.step + 1'b1;
				s_d.st   = NBBM_SEQ;
			end
		end
		NBBM_WB: begin
			s_d.cnt = s_q.cnt + 1'b1;
			if (s_q.cnt == WB_CYC - 1'b1) begin
				s_d.cnt = '0;
				s_d.st  = NBBM_BUSY;
			end
		end
		NBBM_BUSY: begin
			s_d.cnt = s_q.cnt + 1'b1;
			if (s_q.rb2) begin
				s_d.step = s_q.step + 1'b1;
				s_d.st   = NBBM_SEQ;
			end else if (s_q.cnt >= limit) begin
				s_d.rsp_valid = 1'b1;
				s_d.rsp_code  = NBBM_RC_TIMEOUT;
				s_d.ce_n      = 1'b1;
				s_d.cnt       = '0;
				s_d.st        = NBBM_CEH;
			end
		end
		NBBM_FIN: begin
			s_d.ce_n      = 1'b1;
			s_d.cnt       = '0;
			s_d.st        = NBBM_CEH;
			s_d.rsp_valid = 1'b1;
			s_d.rsp_code  = NBBM_RC_OK;
			case (s_q.op)
			NBBM_OP_READ: begin
				s_d.rsp_data = fixd;
				if (odd && fixd != s_q.rd2) begin
					s_d.rsp_code = NBBM_RC_FIXED;
				end else if (!odd && syn != 4'h0) begin
					s_d.rsp_code = NBBM_RC_UNCORR;
				end
			end
			NBBM_OP_PROG, NBBM_OP_ERASE: begin
				s_d.rsp_data = s_q.rd;
				if (s_q.op == NBBM_OP_ERASE) begin
					if (s_q.last_row[15:5] == s_q.pbn) begin
						s_d.nop = 2'h0;
					end
				end else if (row == s_q.last_row) begin
					s_d.nop = s_q.nop + 1'b1;
				end else begin
					s_d.last_row = row;
					s_d.nop      = 2'h1;
				end
				if (s_q.rd[`NBBM_STAT_FAIL]) begin
					s_d.rsp_valid    = 1'b0;
					s_d.good[s_q.pbn] = 1'b0;
					s_d.st           = NBBM_SPARE;
				end
			end
			NBBM_OP_SCAN: begin
				s_d.rsp_valid = 1'b0;
				s_d.more      = 1'b1;
				s_d.step      = 4'h0;
				// block zero is trusted whatever it reads
				if (s_q.rd != `NBBM_ERASED && s_q.pbn != '0) begin
					s_d.good[s_q.pbn] = 1'b0;
				end
				if (s_q.page == '0 && s_q.rd == `NBBM_ERASED) begin
					s_d.page = 5'h01;
				end else begin
					s_d.page = '0;
					s_d.pbn  = s_q.pbn + 1'b1;
					if ((s_q.rd == `NBBM_ERASED || s_q.pbn == '0)
						&& 32'(s_q.lcnt) < LOG_BLOCKS) begin
						map.we    = 1'b1;
						map.waddr = s_q.lcnt[`NBBM_BLK_W-1:0];
						s_d.lcnt  = s_q.lcnt + 1'b1;
						s_d.spare = {1'b0, s_q.pbn} + 1'b1;
					end
					// scan length follows BLOCKS so a smaller part scans faster
					if (32'(s_q.pbn) == BLOCKS - 1) begin
						s_d.more      = 1'b0;
						s_d.scan_done = 1'b1;
						s_d.rsp_valid = 1'b1;
					end
				end
			end
			default: s_d.rsp_data = s_q.rd;
			endcase
		end
		NBBM_SPARE: begin
			// contents move is left to the user, one page buffer is enough
			s_d.spare = s_q.spare + 1'b1;
			if (32'(s_q.spare) >= BLOCKS) begin
				s_d.rsp_valid = 1'b1;
				s_d.rsp_code  = NBBM_RC_FAIL;
				s_d.st        = NBBM_CEH;
			end else if (s_q.good[s_q.spare[`NBBM_BLK_W-1:0]]) begin
				map.we        = 1'b1;
				map.wdata     = s_q.spare[`NBBM_BLK_W-1:0];
				s_d.ret_valid = 1'b1;
				s_d.ret_old   = s_q.pbn;
				s_d.ret_new   = s_q.spare[`NBBM_BLK_W-1:0];
				s_d.rsp_valid = 1'b1;
				s_d.rsp_code  = NBBM_RC_FAIL;
				s_d.st        = NBBM_CEH;
			end
		end
		NBBM_CEH: begin
			s_d.cnt = s_q.cnt + 1'b1;
			if (s_q.cnt >= CEH_CYC - 1'b1 && s_q.rb2) begin
				s_d.cnt = '0;
				s_d.st  = s_q.more ? NBBM_SEQ : NBBM_IDLE;
			end else if (s_q.cnt >= CEH_CYC - 1'b1) begin
				s_d.cnt = CEH_CYC;
			end
		end
		default: s_d.st = NBBM_IDLE;
		endcase
	end

	// ========================================
	// state register, frozen while the clock enable is low
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_q      <= '0;
			s_q.st   <= NBBM_IDLE;
			s_q.ce_n <= 1'b1;
			s_q.we_n <= 1'b1;
			s_q.re_n <= 1'b1;
			s_q.oe_n <= 1'b1;
			s_q.good <= '1;
		end else if (ce_i) begin
			s_q <= s_d;
		end
	end

	assign map.en               = ce_i;
	assign map.raddr            = s_q.lbn;
	assign req_ready_o          = (s_q.st == NBBM_IDLE);
	assign rsp_valid_o          = s_q.rsp_valid;
	assign rsp_code_o           = s_q.rsp_code;
	assign rsp_data_o           = s_q.rsp_data;
	assign retire_valid_o       = s_q.ret_valid;
	assign retire_old_o         = s_q.ret_old;
	assign retire_new_o         = s_q.ret_new;
	assign scan_done_o          = s_q.scan_done;
	assign nand_ce_n_o          = s_q.ce_n;
	assign nand_cle_o           = s_q.cle;
	assign nand_ale_o           = s_q.ale;
	assign nand_we_n_o          = s_q.we_n;
	assign read_strobe_line_n_o = s_q.re_n;
	assign nand_wp_n_o          = s_q.wp_n;
	assign nand_io_o            = s_q.io;
	assign nand_io_oe_n_o       = s_q.oe_n;

	// ========================================
	// checks
	logic [7:0] ceh_q;
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ceh_q <= 8'h00;
		end else if (ce_i) begin
			ceh_q <= s_q.ce_n ? ((ceh_q == 8'hFF) ? ceh_q : ceh_q + 8'h01) : 8'h00;
		end
	end

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i || !ce_i);

	chk_erase_after_scan: assert property (
		(s_q.st == NBBM_LO && s_q.cle && s_q.io == `NBBM_CMD_ERASE)
		|-> s_q.scan_done) else $error("erase before bad-block scan");
	chk_erase_good_only: assert property (
		(s_q.st == NBBM_LO && s_q.cle && s_q.io == `NBBM_CMD_ERASE)
		|-> s_q.good[s_q.pbn]) else $error("erase of a retired block");
	chk_cmd_when_ready: assert property (
		(s_q.st == NBBM_SEQ && $past(s_q.st) == NBBM_BUSY) |-> s_q.rb2)
		else $error("command issued while busy");
	chk_ce_hold_time: assert property (
		$fell(s_q.ce_n) |-> $past(ceh_q) >= 8'(CEH_CYC))
		else $error("chip select high too short");
	chk_busy_bound: assert property (
		(s_q.st == NBBM_BUSY && s_q.op == NBBM_OP_READ) |-> s_q.cnt <= R_CYC)
		else $error("page load wait overran");
	chk_nop_limit: assert property (
		(s_q.st == NBBM_LO && s_q.cle && s_q.io == `NBBM_CMD_PROG)
		|-> !(row == s_q.last_row && s_q.nop == 2'(`NBBM_NOP_MAIN)))
		else $error("too many partial programs");
	chk_retire_on_fail: assert property (
		s_q.ret_valid |-> (s_q.ret_new != s_q.ret_old && s_q.rsp_valid
		&& s_q.rsp_code == NBBM_RC_FAIL && !s_q.good[s_q.ret_old]))
		else $error("bad retire report");
	chk_strobe_width: assert property (
		$fell(s_q.we_n) |-> !s_q.we_n [*8]) else $error("strobe too short");
	chk_rsp_pulse: assert property (
		s_q.rsp_valid |=> !s_q.rsp_valid) else $error("response not a pulse");
endmodule

// ---- nbbm_consts.svh ----
// How it works
// - Per erase a page takes 2 main and 3 spare partial programs at most. The controller counts main programs only for the last programmed page.
// - Ending a sequential row read needs chip select high over 100 ns.
// - Build the bad-block table from factory marks; never erase them. Block 0 is mapped whatever its mark reads.
// - Remap logical blocks onto valid physical blocks only.
// - A failed program or erase status retires the block.
// - Fix single-bit, detect double-bit errors rather than replace blocks.
`ifndef NBBM_CONSTS_SVH
`define NBBM_CONSTS_SVH
// ========================================
// command bytes
`define NBBM_CMD_READ0    8'h00
`define NBBM_CMD_SPARE    8'h50
`define NBBM_CMD_PROG     8'h80
`define NBBM_CMD_PROG_GO  8'h10
`define NBBM_CMD_ERASE    8'h60
`define NBBM_CMD_ERASE_GO 8'hD0
`define NBBM_CMD_STATUS   8'h70
`define NBBM_CMD_RESET    8'hFF
// ========================================
// field positions and values
`define NBBM_MARK_COL     8'h05
`define NBBM_ERASED       8'hFF
`define NBBM_STAT_FAIL    0
`define NBBM_NOP_MAIN     2
`define NBBM_NOP_SPARE    3
`define NBBM_BLOCKS       2048
`define NBBM_LOG_BLOCKS   2013
`define NBBM_BLK_W        11
`define NBBM_PAGE_W       5
`define NBBM_CNT_W        20
// ========================================
// timing
`define NBBM_CLK_MHZ      250
`define NBBM_T_CLK_NS     4
`define NBBM_SYNC_LAT     2
`define NBBM_T_LO_NS      35
`define NBBM_T_HI_NS      20
`define NBBM_T_WB_NS      100
`define NBBM_T_CEH_NS     100
`define NBBM_T_R_US       10
`define NBBM_T_RST_US     5
`define NBBM_T_PROG_US    500
`define NBBM_T_BERS_US    3000
`endif

// ---- nbbm_pkg.sv ----
package nbbm_pkg;
`include "nbbm_consts.svh"
	typedef enum logic [2:0] {
		NBBM_OP_READ  = 3'h0,
		NBBM_OP_PROG  = 3'h1,
		NBBM_OP_ERASE = 3'h2,
		NBBM_OP_RESET = 3'h3,
		NBBM_OP_SCAN  = 3'h4
	} nbbm_op_type;
	typedef enum logic [2:0] {
		NBBM_RC_OK      = 3'h0,
		NBBM_RC_FIXED   = 3'h1,
		NBBM_RC_REFUSED = 3'h2,
		NBBM_RC_FAIL    = 3'h3,
		NBBM_RC_TIMEOUT = 3'h4,
		NBBM_RC_UNCORR  = 3'h5
	} nbbm_code_type;
	typedef enum logic [9:0] {
		NBBM_IDLE  = 10'h001,
		NBBM_MAP   = 10'h002,
		NBBM_SEQ   = 10'h004,
		NBBM_LO    = 10'h008,
		NBBM_HI    = 10'h010,
		NBBM_WB    = 10'h020,
		NBBM_BUSY  = 10'h040,
		NBBM_FIN   = 10'h080,
		NBBM_SPARE = 10'h100,
		NBBM_CEH   = 10'h200
	} nbbm_state_type;
	typedef enum logic [2:0] {
		NBBM_K_CMD  = 3'h0,
		NBBM_K_ADR  = 3'h1,
		NBBM_K_DIN  = 3'h2,
		NBBM_K_DOUT = 3'h3,
		NBBM_K_WAIT = 3'h4,
		NBBM_K_END  = 3'h5
	} nbbm_kind_type;
	typedef struct packed {
		nbbm_state_type          st;
		nbbm_op_type             op;
		logic [3:0]              step;
		logic [`NBBM_CNT_W-1:0]  cnt;
		logic [`NBBM_BLK_W-1:0]  lbn;
		logic [`NBBM_BLK_W-1:0]  pbn;
		logic [`NBBM_PAGE_W-1:0] page;
		logic [6:0]              idx;
		logic [7:0]              data;
		logic [7:0]              rd;
		logic [7:0]              rd2;
		logic [`NBBM_BLK_W:0]    lcnt;
		logic [`NBBM_BLK_W:0]    spare;
		logic [`NBBM_BLOCKS-1:0] good;
		logic                    scan_done;
		logic                    more;
		logic [15:0]             last_row;
		logic [1:0]              nop;
		logic                    rb1;
		logic                    rb2;
		logic [7:0]              io1;
		logic [7:0]              io2;
		logic                    ce_n;
		logic                    cle;
		logic                    ale;
		logic                    we_n;
		logic                    re_n;
		logic                    wp_n;
		logic                    oe_n;
		logic [7:0]              io;
		logic                    rsp_valid;
		nbbm_code_type           rsp_code;
		logic [7:0]              rsp_data;
		logic                    ret_valid;
		logic [`NBBM_BLK_W-1:0]  ret_old;
		logic [`NBBM_BLK_W-1:0]  ret_new;
	} nbbm_st_type;
endpackage

// ---- nbbm_map_if.sv ----
`timescale 1ns/10ps
interface nbbm_map_if #(
	parameter int AW = 11,
	parameter int DW = 11
) ();
	logic          en;
	logic          we;
	logic [AW-1:0] waddr;
	logic [DW-1:0] wdata;
	logic [AW-1:0] raddr;
	logic [DW-1:0] rdata;
	modport mem  (input en, we, waddr, wdata, raddr, output rdata);
	modport ctrl (output en, we, waddr, wdata, raddr, input rdata);
endinterface

// ---- nbbm_map_mem.sv ----
`timescale 1ns/10ps
// logical to physical block map, registered read
module nbbm_map_mem #(
	parameter int AW = 11,
	parameter int DW = 11
) (
	input  wire logic  sys_clk_i,
	input  wire logic  rst_i,
	nbbm_map_if.mem    map
);
	logic [DW-1:0] mem_q [2**AW];
	logic [DW-1:0] rdata_q;

	// ========================================
	// storage has no reset, only the read register does
	always_ff @(posedge sys_clk_i) begin
		if (map.en && map.we) begin
			mem_q[map.waddr] <= map.wdata;
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_q <= '0;
		end else if (map.en) begin
			rdata_q <= mem_q[map.raddr];
		end
	end

	assign map.rdata = rdata_q;
endmodule

// ---- nbbm_dev_model.sv ----
`timescale 1ns/10ps
// ========================================
// small-page flash stand-in: sparse store, absent bytes read erased
module nbbm_dev_model (
	input  wire logic       ce_n_i,
	input  wire logic       cle_i,
	input  wire logic       ale_i,
	input  wire logic       we_n_i,
	input  wire logic       re_n_i,
	input  wire logic       wp_n_i,
	input  wire logic [7:0] io_i,
	input  wire logic       fail_i,
	output logic      [7:0] io_o,
	output logic            rb_o
);
	logic [7:0] mem [int];
	logic [7:0] buf_q [int];
	logic [7:0] cmd_q, last_q;
	logic       stat_q, fail_q;
	int         row_q, col_q, ptr_q, acnt_q, n, busy_viol, mark_erased;
	int         dq [$];
	// stand-in lock code, the controller never sends it
	localparam logic [7:0] LOCK_CMD = 8'hE5;
	// block 0 ships unmarked; blocks 1 and 3 ship bad
	initial begin
		rb_o = 1'b1;
		{cmd_q, last_q, stat_q, fail_q} = '0;
		{row_q, col_q, ptr_q, acnt_q, busy_viol, mark_erased} = '0;
		mem[32768 + 517] = 8'h00;
		mem[3 * 32768 + 1024 + 517] = 8'h3C;
	end
	function automatic logic [7:0] rd(int k);
		return mem.exists(k) ? mem[k] : 8'hFF;
	endfunction
	// busy starts a little after the last write strobe
	task automatic go_busy(int t);
		fork
			begin
				#20 rb_o = 1'b0;
				#t rb_o = 1'b1;
			end
		join_none
	endtask
	// commands, addresses and data latch on the rising write strobe
	always @(posedge we_n_i) if (!ce_n_i) begin
		if (cle_i) begin
			if (!rb_o && io_i != 8'h70 && io_i != 8'hFF)
				busy_viol++;
			acnt_q = 0;
			stat_q = (io_i == 8'h70);
			if (io_i == 8'h00 || io_i == 8'h50 || io_i == 8'h60 || io_i == 8'h80)
				cmd_q = io_i;
			if (io_i == 8'h00 || io_i == 8'h50)
				ptr_q = (io_i == 8'h50) ? 512 : 0;
			if (io_i == 8'h80)
				buf_q.delete();
			case (io_i)
				8'h10: begin
					fail_q = fail_i; // a failed write changes nothing
					if (!fail_i)
						foreach (buf_q[k]) mem[k] = rd(k) & buf_q[k];
					go_busy(400);
				end
				8'hD0: begin
					if (rd((row_q >> 5) * 32768 + 517) != 8'hFF)
						mark_erased++;
					if (rd((row_q >> 5) * 32768 + 1541) != 8'hFF)
						mark_erased++;
					dq.delete();
					foreach (mem[k]) if ((k >> 15) == (row_q >> 5)) dq.push_back(k);
					foreach (dq[j]) mem.delete(dq[j]);
					go_busy(800);
				end
				8'hFF: go_busy(400);
				LOCK_CMD: go_busy(5000);
				default: ;
			endcase
		end else if (ale_i) begin
			n = acnt_q + (cmd_q == 8'h60);
			if (n == 0) col_q = ptr_q + io_i;
			if (n == 1) row_q = io_i;
			if (n == 2) row_q = row_q + io_i * 256;
			if (n == 2 && cmd_q != 8'h80 && cmd_q != 8'h60)
				go_busy(200);
			acnt_q++;
		end else begin
			buf_q[row_q * 1024 + col_q] = io_i;
			col_q++;
		end
	end
	// rising read strobe steps the column
	always @(posedge re_n_i) if (!ce_n_i) begin
		last_q = io_o;
		if (!stat_q)
			col_q++;
	end
	// a released bus shows the inverse of the last byte, never a copy
	always @(ce_n_i, re_n_i, stat_q, col_q, row_q, last_q, rb_o, fail_q)
		if (!ce_n_i && !re_n_i)
			io_o = stat_q ? {wp_n_i, rb_o, 5'h00, fail_q}
				: rd(row_q * 1024 + col_q);
		else
			io_o = ~last_q;
endmodule

// ---- nbbm_ctrl_tb.sv ----
`timescale 1ns/10ps
`define CHK(g, e) begin \
	n_compared++; \
	if ((g) !== (e)) begin \
		n_mismatch++; \
		$display("mismatch t=%0t got %h exp %h", $time, g, e); \
	end \
end
module nbbm_ctrl_tb import nbbm_pkg::*;;
	localparam int LOGB = 8;
	int            seed = 58, n_mismatch = 0, n_compared = 0, j, p, i, k;
	logic          sys_clk_i, rst_i, req_valid, fail, rdy, rv, ret_v, sdone;
	logic          ce_n, cle, ale, we_n, re_n, wp_n, oe_n, rb, got_ret;
	nbbm_op_type   op;
	nbbm_code_type code, got_code;
	logic [10:0]   lbn, ret_o, ret_n, got_old, got_new;
	logic [4:0]    page;
	logic [6:0]    idx;
	logic [7:0]    data, rdat, io_h, io_d, io_w, got_data, d;
	// host drives the shared bus only while its enable is low
	assign io_w = !oe_n ? io_h : io_d;
	nbbm_ctrl #(.BLOCKS(16), .LOG_BLOCKS(LOGB), .PROG_CYC(200),
		.BERS_CYC(400))
	nbbm_ctrl_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(1'b1),
		.req_valid_i(req_valid), .req_ready_o(rdy), .req_op_i(op),
		.req_lbn_i(lbn), .req_page_i(page), .req_idx_i(idx),
		.req_data_i(data), .rsp_valid_o(rv), .rsp_code_o(code),
		.rsp_data_o(rdat), .retire_valid_o(ret_v), .retire_old_o(ret_o),
		.retire_new_o(ret_n), .scan_done_o(sdone), .nand_ce_n_o(ce_n),
		.nand_cle_o(cle), .nand_ale_o(ale), .nand_we_n_o(we_n),
		.read_strobe_line_n_o(re_n), .nand_wp_n_o(wp_n),
		.nand_io_i(io_w), .nand_io_o(io_h), .nand_io_oe_n_o(oe_n),
		.nand_rb_i(rb));
	nbbm_dev_model nbbm_dev_model_inst (.ce_n_i(ce_n), .cle_i(cle),
		.ale_i(ale), .we_n_i(we_n), .re_n_i(re_n), .wp_n_i(wp_n),
		.io_i(io_h), .fail_i(fail), .io_o(io_d), .rb_o(rb));
	// 250 MHz clock
	initial begin
		sys_clk_i = 1'b0;
		forever #2 sys_clk_i = ~sys_clk_i;
	end
	// nth good block, skipping the two shipped bad ones
	function automatic int exp_pbn(int l);
		int b;
		for (b = 0; l > 0 || b == 1 || b == 3; b++)
			if (b != 1 && b != 3) l--;
		return b;
	endfunction
	function automatic int key(int b, int pg, int ix);
		return b * 32768 + pg * 1024 + 2 * ix;
	endfunction
	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// one request, entered at a falling edge; bounded waits throughout
	task automatic run(input nbbm_op_type o, input int l, input int pg,
		input int ix, input logic [7:0] dv);
		int c;
		op = o;
		lbn = l[10:0];
		page = pg[4:0];
		idx = ix[6:0];
		data = dv;
		req_valid = 1'b1;
		for (c = 0; c < 3000 && !rdy; c++) @(negedge sys_clk_i);
		@(negedge sys_clk_i);
		req_valid = 1'b0;
		for (c = 0; c < 20000 && !rv; c++) @(negedge sys_clk_i);
		if (!rv) begin
			n_mismatch++;
			print_verdict();
		end
		got_code = code;
		{got_data, got_ret, got_old, got_new} = {rdat, ret_v, ret_o, ret_n};
	endtask
	// main sequence
	initial begin
		{rst_i, req_valid, fail, lbn, page, idx, data} = {1'b1, 33'h0};
		op = NBBM_OP_READ;
		repeat (2) @(posedge sys_clk_i);
		@(negedge sys_clk_i);
		rst_i = 1'b0;
		repeat (3) @(negedge sys_clk_i);
		run(NBBM_OP_READ, 0, 0, 0, 8'h00);
		`CHK(got_code, NBBM_RC_REFUSED)
		run(NBBM_OP_SCAN, 0, 0, 0, 8'h00);
		`CHK(got_code, NBBM_RC_OK)
		`CHK(sdone, 1'b1)
		`CHK(nbbm_dev_model_inst.rd(32768 + 517), 8'h00)
		$display("test scan done");
		for (j = 0; j < 4; j++) begin
			p = (j == 0) ? 31 : $random(seed) & 31;
			i = (j == 0) ? 127 : $random(seed) & 127;
			d = (j == 0) ? 8'h00 : 8'($random(seed));
			run(NBBM_OP_PROG, j, p, i, d);
			`CHK(got_code, NBBM_RC_OK)
			`CHK(nbbm_dev_model_inst.rd(key(exp_pbn(j), p, i)), d)
			run(NBBM_OP_READ, j, p, i, 8'h00);
			`CHK(got_data, d)
		end
		$display("test program read done");
		k = key(exp_pbn(3), p, i);
		nbbm_dev_model_inst.mem[k] = nbbm_dev_model_inst.mem[k] ^ 8'h10;
		run(NBBM_OP_READ, 3, p, i, 8'h00);
		`CHK(got_code, NBBM_RC_FIXED)
		`CHK(got_data, d)
		nbbm_dev_model_inst.mem[k] = nbbm_dev_model_inst.mem[k] ^ 8'h01;
		run(NBBM_OP_READ, 3, p, i, 8'h00);
		`CHK(got_code, NBBM_RC_UNCORR)
		$display("test correction done");
		run(NBBM_OP_ERASE, 4, 0, 0, 8'h00);
		`CHK(got_code, NBBM_RC_OK)
		for (j = 0; j < 3; j++) begin
			run(NBBM_OP_PROG, 4, 5, j, 8'hA5);
			`CHK(got_code, (j < 2) ? NBBM_RC_OK : NBBM_RC_REFUSED)
		end
		run(NBBM_OP_ERASE, 4, 0, 0, 8'h00);
		`CHK(nbbm_dev_model_inst.rd(key(exp_pbn(4), 5, 0)), 8'hFF)
		run(NBBM_OP_PROG, 4, 5, 0, 8'h5A);
		`CHK(got_code, NBBM_RC_OK)
		run(NBBM_OP_READ, LOGB, 0, 0, 8'h00);
		`CHK(got_code, NBBM_RC_REFUSED)
		$display("test partial done");
		fail = 1'b1;
		run(NBBM_OP_PROG, 5, 2, 9, 8'h3C);
		fail = 1'b0;
		`CHK(got_code, NBBM_RC_FAIL)
		`CHK(got_ret, 1'b1)
		`CHK(got_old, 11'(exp_pbn(5)))
		`CHK(got_new, 11'h00A)
		run(NBBM_OP_PROG, 5, 2, 9, 8'h3C);
		`CHK(nbbm_dev_model_inst.rd(key(10, 2, 9)), 8'h3C)
		run(NBBM_OP_RESET, 0, 0, 0, 8'h00);
		`CHK(got_code, NBBM_RC_OK)
		`CHK(nbbm_dev_model_inst.busy_viol, 0)
		`CHK(nbbm_dev_model_inst.mark_erased, 0)
		$display("test retire done");
		print_verdict();
	end
endmodule
